// file: rtl/msk_modem_bit_interface.sv
`timescale 1ns/100ps
module msk_modem_bit_interface (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic master_clock_in,
    input wire logic clock_divide_select_in,
    input wire logic tx_request_clear_in,
    input wire logic rx_ready_clear_in,
    input wire logic lock_range_select_in,
    input wire logic tx_serial_in,
    input wire logic modulator_on_in,
    input wire logic modulated_in,
    output logic tx_bit_clock_out,
    output logic tx_request_flag_out,
    output logic modulated_out,
    output logic rx_bit_clock_out,
    output logic rx_serial_out,
    output logic rx_ready_flag_out,
    output logic carrier_detect_out,
    output logic irq_out
);

    msk_modem_pkg::pin_in_t pins_raw;
    msk_modem_pkg::pin_in_t pins_meta;
    msk_modem_pkg::pin_in_t pins;
    msk_modem_pkg::ctrl_t ctrl;
    logic master_d;
    logic master_rise;
    logic [1:0] step;
    logic [12:0] tx_phase;
    logic [12:0] next_tx_phase;
    logic tx_lead;
    logic tx_bit;
    logic [12:0] tone_cnt;
    logic [12:0] tone_half;
    logic [12:0] rx_phase;
    logic [12:0] rx_base;
    logic [12:0] rx_add;
    logic [12:0] rx_adj;
    logic [12:0] next_rx_phase;
    logic rx_lead;
    logic demod_bit;
    logic demod_transition;
    logic tone_carrier;
    logic carrier_d;
    logic [msk_modem_pkg::NUM_EVENTS-1:0] events;
    logic [msk_modem_pkg::NUM_EVENTS-1:0] irq_status;
    logic [msk_modem_pkg::NUM_EVENTS-1:0] irq_mask;
    logic [msk_modem_pkg::NUM_EVENTS-1:0] w1c;
    logic apb_setup;
    logic apb_write;
    logic [31:0] next_rdata;
    logic next_err;

    // advance a bit phase, wrapping at one bit period
    function automatic logic [12:0] advance(input logic [12:0] ph,
                                            input logic [12:0] add);
        logic [13:0] sum;
        sum = {1'b0, ph} + {1'b0, add};
        if (sum >= {1'b0, msk_modem_pkg::TICKS_PER_BIT}) begin
            sum = sum - {1'b0, msk_modem_pkg::TICKS_PER_BIT};
        end
        return sum[12:0];
    endfunction : advance

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for every pin input
    assign pins_raw = '{master_clock: master_clock_in,
                        clock_divide_select: clock_divide_select_in,
                        tx_request_clear: tx_request_clear_in,
                        rx_ready_clear: rx_ready_clear_in,
                        lock_range_select: lock_range_select_in,
                        tx_serial: tx_serial_in,
                        modulator_on: modulator_on_in,
                        modulated: modulated_in};

    for (genvar i = 0; i < msk_modem_pkg::NUM_PINS; i++) begin : g_sync
        always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
                pins_meta[i] <= 1'b0;
                pins[i] <= 1'b0;
            end else begin
                pins_meta[i] <= pins_raw[i];
                pins[i] <= pins_meta[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master clock rising edges become phase ticks, slow master counts double
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            master_d <= 1'b0;
        end else begin
            master_d <= pins.master_clock;
        end
    end

    assign master_rise = pins.master_clock && !master_d;
    assign step = !master_rise ? 2'h0 :
                  pins.clock_divide_select ? msk_modem_pkg::SLOW_STEP :
                  msk_modem_pkg::FAST_STEP;

    ////////////////////////////////////////////////////////////////////////
    // transmit bit timing, one wrap per 1200 bit/s period
    assign next_tx_phase = advance(tx_phase, {11'h000, step});
    assign tx_lead = (step != 2'h0) && (next_tx_phase < tx_phase);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_phase <= 13'h0000;
            tx_bit_clock_out <= 1'b0;
        end else begin
            tx_phase <= next_tx_phase;
            tx_bit_clock_out <= (next_tx_phase < msk_modem_pkg::HALF_BIT);
        end
    end

    // NRZ bit taken at each transmit clock leading edge
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_bit <= 1'b1;
        end else if (tx_lead) begin
            tx_bit <= pins.tx_serial;
        end
    end

    // request flag: set per bit, cleared by host, set wins
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_request_flag_out <= 1'b0;
        end else if (tx_lead && ctrl.tx_enable) begin
            tx_request_flag_out <= 1'b1;
        end else if (pins.tx_request_clear) begin
            tx_request_flag_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tone generator, silent unless modulator on and transmit enabled
    assign tone_half = tx_bit ? msk_modem_pkg::MARK_HALF :
                       msk_modem_pkg::SPACE_HALF;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tone_cnt <= 13'h0000;
            modulated_out <= 1'b0;
        end else if (!pins.modulator_on || !ctrl.tx_enable) begin
            tone_cnt <= 13'h0000;
            modulated_out <= 1'b0;
        end else if (tone_cnt + {11'h000, step} >= tone_half) begin
            tone_cnt <= 13'h0000;
            modulated_out <= !modulated_out;
        end else begin
            tone_cnt <= tone_cnt + {11'h000, step};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive tone detection and carrier sense
    msk_tone_detect u_detect (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .step_in(step),
        .tone_in(pins.modulated),
        .enable_in(ctrl.rx_enable),
        .bit_out(demod_bit),
        .transition_out(demod_transition),
        .carrier_out(tone_carrier)
    );

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            carrier_detect_out <= 1'b0;
            carrier_d <= 1'b0;
        end else begin
            carrier_detect_out <= tone_carrier && ctrl.rx_enable;
            carrier_d <= carrier_detect_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive clock recovery, pulls transitions toward mid phase
    assign rx_adj = pins.lock_range_select ? msk_modem_pkg::NARROW_ADJ :
                    msk_modem_pkg::WIDE_ADJ;

    always_comb begin
        rx_base = rx_phase;
        rx_add = {11'h000, step};
        if (demod_transition && rx_phase < msk_modem_pkg::HALF_BIT) begin
            rx_add = {11'h000, step} + rx_adj; // late clock, speed up
        end else if (demod_transition) begin
            rx_base = rx_phase - rx_adj; // early clock, hold back
        end
    end

    assign next_rx_phase = advance(rx_base, rx_add);
    assign rx_lead = (rx_add != 13'h0000) && (next_rx_phase < rx_base);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_phase <= 13'h0000;
            rx_bit_clock_out <= 1'b0;
        end else begin
            rx_phase <= next_rx_phase;
            rx_bit_clock_out <= (next_rx_phase < msk_modem_pkg::HALF_BIT);
        end
    end

    // received bit presented at the recovered clock leading edge
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_serial_out <= 1'b1;
        end else if (rx_lead && ctrl.rx_enable) begin
            rx_serial_out <= demod_bit;
        end
    end

    // ready flag: set per recovered bit, cleared by host, set wins
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_ready_flag_out <= 1'b0;
        end else if (rx_lead && ctrl.rx_enable) begin
            rx_ready_flag_out <= 1'b1;
        end else if (pins.rx_ready_clear) begin
            rx_ready_flag_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, new event wins
    assign events[msk_modem_pkg::EV_TX_REQUEST] = tx_lead && ctrl.tx_enable;
    assign events[msk_modem_pkg::EV_RX_READY] = rx_lead && ctrl.rx_enable;
    assign events[msk_modem_pkg::EV_CARRIER] = carrier_d ^ carrier_detect_out;
    assign w1c = (apb_write && paddr_in == msk_modem_pkg::ADDR_IRQ_STATUS) ?
                 pwdata_in[msk_modem_pkg::NUM_EVENTS-1:0] : '0;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~w1c) | events;
        end
    end

    assign irq_out = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states, read data latched in setup
    assign apb_setup = psel_in && !penable_in;
    assign apb_write = psel_in && penable_in && pwrite_in;
    assign pready_out = 1'b1;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ctrl <= msk_modem_pkg::CTRL_RESET;
            irq_mask <= msk_modem_pkg::IRQ_MASK_RESET;
        end else if (apb_write) begin
            if (paddr_in == msk_modem_pkg::ADDR_CTRL) begin
                ctrl <= '{unused: 30'h0,
                          rx_enable: pwdata_in[msk_modem_pkg::CTRL_RX_EN_BIT],
                          tx_enable: pwdata_in[msk_modem_pkg::CTRL_TX_EN_BIT]};
            end
            if (paddr_in == msk_modem_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= pwdata_in[msk_modem_pkg::NUM_EVENTS-1:0];
            end
        end
    end

    // read mux and error decode
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        unique case (paddr_in)
            msk_modem_pkg::ADDR_CTRL: begin
                next_rdata = ctrl;
            end
            msk_modem_pkg::ADDR_STATUS: begin
                next_rdata[msk_modem_pkg::ST_TX_FLAG] = tx_request_flag_out;
                next_rdata[msk_modem_pkg::ST_RX_FLAG] = rx_ready_flag_out;
                next_rdata[msk_modem_pkg::ST_CARRIER] = carrier_detect_out;
                next_rdata[msk_modem_pkg::ST_RX_DATA] = rx_serial_out;
                next_rdata[msk_modem_pkg::ST_DIV_SEL] =
                    pins.clock_divide_select;
                next_rdata[msk_modem_pkg::ST_LOCK_SEL] = pins.lock_range_select;
                next_rdata[msk_modem_pkg::ST_MOD_ON] = pins.modulator_on;
            end
            msk_modem_pkg::ADDR_IRQ_STATUS: begin
                next_rdata[msk_modem_pkg::NUM_EVENTS-1:0] = irq_status;
            end
            msk_modem_pkg::ADDR_IRQ_MASK: begin
                next_rdata[msk_modem_pkg::NUM_EVENTS-1:0] = irq_mask;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else if (apb_setup) begin
            prdata_out <= next_rdata;
            pslverr_out <= next_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the block's own behaviour
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_divider_step: assert property (master_rise |->
        step == (pins.clock_divide_select ? 2'h2 : 2'h1))
        else $error("tick step does not follow divide select");

    a_phase_range: assert property (
        tx_phase < msk_modem_pkg::TICKS_PER_BIT &&
        rx_phase < msk_modem_pkg::TICKS_PER_BIT)
        else $error("bit phase beyond one bit period");

    a_tx_clock_rise: assert property (tx_lead |=>
        $rose(tx_bit_clock_out))
        else $error("transmit clock did not rise at bit start");

    a_tx_flag_set: assert property (tx_lead && ctrl.tx_enable |=>
        tx_request_flag_out)
        else $error("transmit request flag not set");

    a_tx_flag_clear: assert property (
        pins.tx_request_clear && !(tx_lead && ctrl.tx_enable) |=>
        !tx_request_flag_out)
        else $error("transmit request flag not cleared");

    a_rx_flag_set: assert property (rx_lead && ctrl.rx_enable |=>
        rx_ready_flag_out && $rose(rx_bit_clock_out))
        else $error("receive ready flag not set with clock");

    a_rx_flag_clear: assert property (
        pins.rx_ready_clear && !(rx_lead && ctrl.rx_enable) |=>
        !rx_ready_flag_out)
        else $error("receive ready flag not cleared");

    a_lock_narrow: assert property (
        demod_transition && pins.lock_range_select &&
        rx_phase >= msk_modem_pkg::HALF_BIT |=>
        rx_phase == 13'($past(rx_phase) - 13'h0010 +
                        {11'h000, $past(step)}))
        else $error("narrow range correction wrong");

    a_tx_data_take: assert property (tx_lead |=>
        tx_bit == $past(pins.tx_serial))
        else $error("transmit bit not taken at clock edge");

    a_rx_data_out: assert property (rx_lead && ctrl.rx_enable |=>
        rx_serial_out == $past(demod_bit))
        else $error("received bit not presented");

    a_carrier_gate: assert property (!ctrl.rx_enable |=>
        !carrier_detect_out)
        else $error("carrier shown while receive disabled");

    a_tx_once_bit: assert property (tx_lead |=> !tx_lead [*8])
        else $error("transmit request set twice in one bit");

    c_tx_request: cover property (tx_lead && ctrl.tx_enable);
    c_rx_ready: cover property (rx_lead && ctrl.rx_enable);
    c_carrier_up: cover property ($rose(carrier_detect_out));
    c_irq_raised: cover property ($rose(irq_out));

endmodule : msk_modem_bit_interface

// file: rtl/msk_modem_pkg.sv
package msk_modem_pkg;

    // master clock figures, ticks are counted in fast-master units
    localparam int MASTER_FAST_HZ = 5529600;
    localparam int MASTER_SLOW_HZ = 2764800;
    localparam int BIT_RATE_BPS = 1200;
    localparam logic [12:0] TICKS_PER_BIT = 13'(MASTER_FAST_HZ / BIT_RATE_BPS);
    localparam logic [12:0] HALF_BIT = 13'(MASTER_FAST_HZ / BIT_RATE_BPS / 2);
    // a slow master edge is worth this many fast-master ticks
    localparam logic [1:0] SLOW_STEP = 2'(MASTER_FAST_HZ / MASTER_SLOW_HZ);
    localparam logic [1:0] FAST_STEP = 2'h1;

    // tone half periods: mark 1200 Hz, space 1800 Hz
    localparam logic [12:0] MARK_HALF = 13'h0900;
    localparam logic [12:0] SPACE_HALF = 13'h0600;
    localparam logic [12:0] DECIDE_HALF = 13'h0780;
    localparam logic [12:0] VALID_MIN = 13'h0480;
    localparam logic [12:0] VALID_MAX = 13'h0C00;
    localparam logic [3:0] CARRIER_COUNT = 4'h8;

    // clock recovery phase corrections per data transition
    localparam logic [12:0] NARROW_ADJ = 13'h0010;
    localparam logic [12:0] WIDE_ADJ = 13'h0080;

    // register map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

    // control fields
    localparam int CTRL_TX_EN_BIT = 0;
    localparam int CTRL_RX_EN_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // event bits in irq status and mask
    localparam int NUM_EVENTS = 3;
    localparam int EV_TX_REQUEST = 0;
    localparam int EV_RX_READY = 1;
    localparam int EV_CARRIER = 2;

    // status fields
    localparam int ST_TX_FLAG = 0;
    localparam int ST_RX_FLAG = 1;
    localparam int ST_CARRIER = 2;
    localparam int ST_RX_DATA = 3;
    localparam int ST_DIV_SEL = 4;
    localparam int ST_LOCK_SEL = 5;
    localparam int ST_MOD_ON = 6;

    localparam int NUM_PINS = 8;

    // asynchronous pin inputs, synchronised as one group
    typedef struct packed {
        logic master_clock;
        logic clock_divide_select;
        logic tx_request_clear;
        logic rx_ready_clear;
        logic lock_range_select;
        logic tx_serial;
        logic modulator_on;
        logic modulated;
    } pin_in_t;

    typedef struct packed {
        logic [29:0] unused;
        logic rx_enable;
        logic tx_enable;
    } ctrl_t;

endpackage : msk_modem_pkg

// file: rtl/msk_tone_detect.sv
`timescale 1ns/100ps
module msk_tone_detect (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] step_in,
    input wire logic tone_in,
    input wire logic enable_in,
    output logic bit_out,
    output logic transition_out,
    output logic carrier_out
);

    logic tone_d;
    logic edge_seen;
    logic half_valid;
    logic next_bit;
    logic [12:0] half_cnt;
    logic [3:0] good_cnt;

    ////////////////////////////////////////////////////////////////////////
    // half-period measurement between tone edges
    assign edge_seen = tone_in ^ tone_d;
    assign half_valid = (half_cnt >= msk_modem_pkg::VALID_MIN) &&
                        (half_cnt <= msk_modem_pkg::VALID_MAX);
    assign next_bit = (half_cnt >= msk_modem_pkg::DECIDE_HALF);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tone_d <= 1'b0;
            half_cnt <= 13'h0000;
        end else begin
            tone_d <= tone_in;
            if (edge_seen) begin
                half_cnt <= 13'h0000;
            end else if (half_cnt <= msk_modem_pkg::VALID_MAX) begin
                half_cnt <= half_cnt + {11'h000, step_in}; // saturates above max
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mark/space decision, long half period means mark
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            bit_out <= 1'b1;
            transition_out <= 1'b0;
        end else begin
            transition_out <= 1'b0;
            if (edge_seen && half_valid && enable_in) begin
                bit_out <= next_bit;
                transition_out <= (next_bit != bit_out);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carrier present after a run of valid half periods
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            good_cnt <= 4'h0;
            carrier_out <= 1'b0;
        end else begin
            if (!enable_in || half_cnt > msk_modem_pkg::VALID_MAX) begin
                good_cnt <= 4'h0; // silence or disabled drops carrier
            end else if (edge_seen) begin
                if (!half_valid) begin
                    good_cnt <= 4'h0;
                end else if (good_cnt != msk_modem_pkg::CARRIER_COUNT) begin
                    good_cnt <= good_cnt + 4'h1;
                end
            end
            carrier_out <= (good_cnt == msk_modem_pkg::CARRIER_COUNT);
        end
    end

endmodule : msk_tone_detect

// file: tb/host_model.sv
`timescale 1ns/100ps
// host controller: serves each bit request and each received bit
module host_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic mod_enable_in,
    input wire logic tx_bit_clock_in,
    input wire logic tx_request_flag_in,
    input wire logic rx_ready_flag_in,
    output logic tx_serial_out,
    output logic modulator_on_out,
    output logic tx_request_clear_out,
    output logic rx_ready_clear_out
);
    logic [5:0] tx_hold;
    logic [5:0] rx_hold;
    logic tcl_q;
    ////////////////////////////////////////////////////////////////////////
    // clears stay high 48 cycles, over 1 us at 40 MHz
    assign tx_request_clear_out = (tx_hold != 6'h00);
    assign rx_ready_clear_out = (rx_hold != 6'h00);
    // service counters, data bit and modulator control
    always @(posedge clk_in) begin
        tcl_q <= tx_bit_clock_in;
        if (rst_in) begin
            tx_hold <= 6'h00;
            rx_hold <= 6'h00;
            tx_serial_out <= 1'b0;
            modulator_on_out <= 1'b0;
        end else begin
            if (tx_hold != 6'h00) tx_hold <= tx_hold - 6'h01;
            else if (tx_request_flag_in) tx_hold <= 6'h30;
            if (rx_hold != 6'h00) rx_hold <= rx_hold - 6'h01;
            else if (rx_ready_flag_in) rx_hold <= 6'h30;
            if (tx_request_flag_in) tx_serial_out <= 1'b0;
            // on at a leading edge, off at the edge after the last bit
            if (tx_bit_clock_in && !tcl_q) begin
                modulator_on_out <= mod_enable_in;
            end
        end
    end
endmodule : host_model

// file: tb/tb_msk_modem_bit_interface.sv
`timescale 1ns/100ps
module tb_msk_modem_bit_interface;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0] mdiv;
    logic div_sel, lock_sel, tx_clr, rx_clr, tx_dat, mod_on, mod_in, mod_en;
    logic tx_clk, tx_flag, mod_out, rx_clk, rx_dat, rx_flag, carrier, irq;
    int errors, checks_done, n, m;
    msk_modem_bit_interface dut (
        .core_clk_in(clk), .rst_in(rst), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .master_clock_in(mdiv[1]), .clock_divide_select_in(div_sel),
        .tx_request_clear_in(tx_clr), .rx_ready_clear_in(rx_clr),
        .lock_range_select_in(lock_sel), .tx_serial_in(tx_dat),
        .modulator_on_in(mod_on), .modulated_in(mod_in),
        .tx_bit_clock_out(tx_clk), .tx_request_flag_out(tx_flag),
        .modulated_out(mod_out), .rx_bit_clock_out(rx_clk),
        .rx_serial_out(rx_dat), .rx_ready_flag_out(rx_flag),
        .carrier_detect_out(carrier), .irq_out(irq));
    host_model host (.clk_in(clk), .rst_in(rst), .mod_enable_in(mod_en),
        .tx_bit_clock_in(tx_clk), .tx_request_flag_in(tx_flag),
        .rx_ready_flag_in(rx_flag), .tx_serial_out(tx_dat),
        .modulator_on_out(mod_on), .tx_request_clear_out(tx_clr),
        .rx_ready_clear_out(rx_clr));
    ////////////////////////////////////////////////////////////////////////
    // 10 MHz master clock pin and tone loopback
    always @(posedge clk) begin
        mdiv <= mdiv + 2'h1;
        mod_in <= mod_out;
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    function automatic logic pick(input int k);
        case (k)
            0: return tx_clk;
            1: return tx_flag;
            2: return carrier;
            default: return rx_flag;
        endcase
    endfunction : pick
    // bounded wait for a pin level, cycles counted in cnt
    task wait_lvl(input int k, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (pick(k) !== v && cnt < lim) begin
            @(posedge clk);
            cnt++;
        end
        if (cnt >= lim) begin
            errors++;
            $display("[ERR] wait %0d expected %b seen timeout", k, v);
            summarize();
        end
    endtask : wait_lvl
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int w;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (w >= 50) begin
            errors++;
            summarize();
        end
    endtask : apb
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, psel, penable, pwrite, div_sel, lock_sel} = 6'h20;
        {paddr, pwdata, mdiv, mod_en, errors, checks_done} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("tx flag", 32'h0, tx_flag);
        apb(1'b0, msk_modem_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", msk_modem_pkg::CTRL_RESET, rdata);
        apb(1'b0, msk_modem_pkg::ADDR_IRQ_MASK, 32'h0);
        chk("mask", 32'h0, rdata);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, rerr);
        apb(1'b1, msk_modem_pkg::ADDR_IRQ_MASK, 32'h1);
        mod_en <= 1'b1;
        wait_lvl(1, 1'b1, 20000, n);
        chk("tx clock", 32'h1, tx_clk);
        chk("irq", 32'h1, irq);
        chk("tone off", 32'h0, mod_out);
        wait_lvl(0, 1'b0, 20000, n);
        chk("flag cleared", 32'h0, tx_flag);
        wait_lvl(0, 1'b1, 20000, m);
        chk("period low", 32'd18432, n + m);
        apb(1'b0, msk_modem_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk("irq tx bit", 32'h1, rdata[0]);
        apb(1'b1, msk_modem_pkg::ADDR_IRQ_STATUS, 32'h1);
        chk("irq cleared", 32'h0, irq);
        div_sel <= 1'b1;
        lock_sel <= 1'b1;
        wait_lvl(0, 1'b0, 20000, n);
        wait_lvl(0, 1'b1, 20000, n);
        wait_lvl(0, 1'b0, 20000, n);
        wait_lvl(0, 1'b1, 20000, m);
        chk("period high", 32'd9216, n + m);
        wait_lvl(2, 1'b1, 60000, n);
        wait_lvl(3, 1'b0, 200, n);
        wait_lvl(3, 1'b1, 40000, n);
        chk("rx data", 32'h0, rx_dat);
        wait_lvl(3, 1'b0, 200, n);
        chk("rx flag cleared", 32'h0, rx_flag);
        summarize();
    end
endmodule : tb_msk_modem_bit_interface
